// ==== rtl/fsq_host.sv ====
// Functional notes
// - sector number lines held at target sector on every byte load strobe
// - all 256 bytes loaded before the program cycle may start
// - byte loads within a sector spaced 150 us or less; the host allows up to 150.4 us, its wait starts after each high phase
// - toggle read is a pulse of output gate; each pulse samples anew
// - polling reads keep one unchanged address
// - id entry is AA/5555, 55/2AAA, 90/5555, then 20 ms wait
// - protection preamble precedes any sector byte load
`timescale 1ns/1ns
`default_nettype none

module fsq_host
#(
  parameter int PROG_TIMEOUT_CYC = fsq_pkg::PROG_CYCLE_CYC,
  parameter int ID_WAIT_CYC      = fsq_pkg::ID_WAIT_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [2:0]  cmd_op_i,
  input  wire logic [9:0]  cmd_sector_i,
  input  wire logic [17:0] cmd_addr_i,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wdata_valid_i,
  output logic             wdata_ready_o,
  output logic [7:0]       rdata_o,
  output logic             rdata_valid_o,
  output logic             done_o,
  output logic             timeout_o,
  output logic [17:0]      flash_addr_o,
  output logic             flash_ce_n_o,
  output logic             flash_oe_n_o,
  output logic             flash_we_n_o,
  output logic [7:0]       flash_dq_o,
  output logic             flash_dq_oe_n_o,
  input  wire logic [7:0]  flash_dq_i
);

  typedef enum logic [3:0]
  {
    ST_IDLE   = 4'h0,
    ST_CMDSEQ = 4'h1,
    ST_WLOW   = 4'h2,
    ST_WHIGH  = 4'h3,
    ST_LOAD   = 4'h4,
    ST_POLLLO = 4'h5,
    ST_POLLHI = 4'h6,
    ST_WAIT   = 4'h7,
    ST_RDLO   = 4'h8,
    ST_DONE   = 4'h9
  } fsq_state_t;

  fsq_state_t       state_reg;
  fsq_pkg::fsq_op_t op_reg;
  logic [2:0]       seq_idx_reg;
  logic [2:0]       seq_len_reg;
  logic [8:0]       byte_cnt_reg;
  logic [9:0]       sector_reg;
  logic [17:0]      addr_reg;
  logic [31:0]      timer_reg;
  logic [31:0]      guard_reg;
  logic             have_sample_reg;
  logic             last_tog_reg;
  logic             last_b7_reg;
  logic [22:0]      seq_cur;
  logic [7:0]       dq_s1_reg;
  logic [7:0]       dq_s2_reg;
  logic [7:0]       dq_s3_reg;
  logic [7:0]       fifo_data;
  logic             fifo_valid;
  logic             fifo_pop;

  // byte stream buffer; the sequencer drains it only during loads
  fsq_fifo
  #(
    .WIDTH (fsq_pkg::DATA_W),
    .DEPTH (fsq_pkg::FIFO_DEPTH)
  )
  u_fifo
  (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (wdata_i),
    .in_valid_i  (wdata_valid_i),
    .in_ready_o  (wdata_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // a load byte is taken when the write pulse opens
  assign fifo_pop = (state_reg == ST_LOAD) && fifo_valid;

  // command preamble word: {address, data}, addresses are 15 bits
  function automatic logic [22:0] seq_word(input fsq_pkg::fsq_op_t op,
                                           input logic [2:0] idx);
    logic [7:0] last;
    last = fsq_pkg::CMD_PROTECT;
    case (op)
      fsq_pkg::FSQ_OP_ID_ENTER: last = fsq_pkg::CMD_ID_ENTER;
      fsq_pkg::FSQ_OP_ID_EXIT:  last = fsq_pkg::CMD_ID_EXIT;
      fsq_pkg::FSQ_OP_LOCK_LO:  last = fsq_pkg::CMD_LOCK_LO;
      fsq_pkg::FSQ_OP_LOCK_HI:  last = fsq_pkg::CMD_LOCK_HI;
      default:                  last = fsq_pkg::CMD_PROTECT;
    endcase
    case (idx)
      3'h0:    seq_word = {fsq_pkg::CMD_ADDR_A, fsq_pkg::CMD_DATA_AA};
      3'h1:    seq_word = {fsq_pkg::CMD_ADDR_B, fsq_pkg::CMD_DATA_55};
      3'h2:    seq_word = {fsq_pkg::CMD_ADDR_A,
                           (op == fsq_pkg::FSQ_OP_LOCK_LO ||
                            op == fsq_pkg::FSQ_OP_LOCK_HI) ?
                           fsq_pkg::CMD_LOCKOUT : last};
      3'h3:    seq_word = {fsq_pkg::CMD_ADDR_A, fsq_pkg::CMD_DATA_AA};
      3'h4:    seq_word = {fsq_pkg::CMD_ADDR_B, fsq_pkg::CMD_DATA_55};
      default: seq_word = {fsq_pkg::CMD_ADDR_A, last};
    endcase
  endfunction

  // current preamble word, split into address and data below
  assign seq_cur = seq_word(op_reg, seq_idx_reg);

  // three-stage sampler for the returning data pins
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
      dq_s3_reg <= 8'h00;
    end
    else
    begin
      dq_s1_reg <= flash_dq_i;
      dq_s2_reg <= dq_s1_reg;
      dq_s3_reg <= dq_s2_reg;
    end
  end

  // main sequencer: commands, loads, polling, waits
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg       <= ST_IDLE;
      op_reg          <= fsq_pkg::FSQ_OP_READ;
      seq_idx_reg     <= 3'h0;
      seq_len_reg     <= 3'h0;
      byte_cnt_reg    <= 9'h000;
      sector_reg      <= 10'h000;
      addr_reg        <= 18'h00000;
      timer_reg       <= 32'h0;
      guard_reg       <= 32'h0;
      have_sample_reg <= 1'b0;
      last_tog_reg    <= 1'b0;
      last_b7_reg     <= 1'b0;
      cmd_ready_o     <= 1'b0;
      rdata_o         <= 8'h00;
      rdata_valid_o   <= 1'b0;
      done_o          <= 1'b0;
      timeout_o       <= 1'b0;
      flash_addr_o    <= 18'h00000;
      flash_ce_n_o    <= 1'b1;
      flash_oe_n_o    <= 1'b1;
      flash_we_n_o    <= 1'b1;
      flash_dq_o      <= 8'h00;
      flash_dq_oe_n_o <= 1'b1;
    end
    else
    begin
      rdata_valid_o <= 1'b0;
      done_o        <= 1'b0;
      cmd_ready_o   <= (state_reg == ST_IDLE) && !cmd_valid_i;
      case (state_reg)
        ST_IDLE:
        begin
          if (cmd_valid_i && cmd_ready_o)
          begin
            op_reg       <= fsq_pkg::fsq_op_t'(cmd_op_i);
            sector_reg   <= cmd_sector_i;
            addr_reg     <= cmd_addr_i;
            seq_idx_reg  <= 3'h0;
            byte_cnt_reg <= 9'h000;
            timeout_o    <= 1'b0;
            cmd_ready_o  <= 1'b0;
            // lock and id exit take six writes, program and id entry three
            seq_len_reg  <= (cmd_op_i == fsq_pkg::FSQ_OP_ID_EXIT ||
                             cmd_op_i == fsq_pkg::FSQ_OP_LOCK_LO ||
                             cmd_op_i == fsq_pkg::FSQ_OP_LOCK_HI) ?
                            3'h6 : 3'h3;
            // all reads: caller address on every line, gate opened at once
            if (cmd_op_i == fsq_pkg::FSQ_OP_READ)
            begin
              state_reg    <= ST_RDLO;
              flash_addr_o <= cmd_addr_i;
              flash_ce_n_o <= 1'b0;
              flash_oe_n_o <= 1'b0;
              timer_reg    <= 32'(fsq_pkg::RD_ACC_CYC);
            end
            else
            begin
              state_reg <= ST_CMDSEQ;
            end
          end
        end
        ST_CMDSEQ:
        begin
          // preamble before any load, fifteen-bit command addresses
          flash_addr_o    <= {3'b000, seq_cur[22:8]};
          flash_dq_o      <= seq_cur[7:0];
          flash_dq_oe_n_o <= 1'b0;
          flash_ce_n_o    <= 1'b0;
          flash_we_n_o    <= 1'b0;
          timer_reg       <= 32'(fsq_pkg::WR_PULSE_CYC);
          seq_idx_reg     <= seq_idx_reg + 3'h1;
          state_reg       <= ST_WLOW;
        end
        ST_WLOW:
        begin
          if (timer_reg > 32'h1)
          begin
            timer_reg <= timer_reg - 32'h1;
          end
          else
          begin
            flash_we_n_o <= 1'b1;
            flash_ce_n_o <= 1'b1;
            timer_reg    <= 32'(fsq_pkg::WR_HIGH_CYC);
            state_reg    <= ST_WHIGH;
          end
        end
        ST_WHIGH:
        begin
          if (timer_reg > 32'h1)
          begin
            timer_reg <= timer_reg - 32'h1;
          end
          else if (seq_idx_reg != seq_len_reg)
          begin
            state_reg <= ST_CMDSEQ;
          end
          else if (op_reg == fsq_pkg::FSQ_OP_PROGRAM)
          begin
            if (byte_cnt_reg == 9'(fsq_pkg::SECTOR_BYTES))
            begin
              // whole sector loaded; start polling
              flash_dq_oe_n_o <= 1'b1;
              guard_reg       <= 32'(PROG_TIMEOUT_CYC);
              have_sample_reg <= 1'b0;
              state_reg       <= ST_POLLLO;
            end
            else
            begin
              guard_reg <= 32'(fsq_pkg::BYTE_LOAD_CYC);
              state_reg <= ST_LOAD;
            end
          end
          else
          begin
            // id entry and lock settle for the full wait
            flash_dq_oe_n_o <= 1'b1;
            timer_reg       <= 32'(ID_WAIT_CYC);
            state_reg       <= ST_WAIT;
          end
        end
        ST_LOAD:
        begin
          if (fifo_valid)
          begin
            // sector number on upper lines, byte index below
            flash_addr_o <= {sector_reg, byte_cnt_reg[7:0]};
            flash_dq_o   <= fifo_data;
            last_b7_reg  <= fifo_data[7];
            flash_ce_n_o <= 1'b0;
            flash_we_n_o <= 1'b0;
            byte_cnt_reg <= byte_cnt_reg + 9'h001;
            timer_reg    <= 32'(fsq_pkg::WR_PULSE_CYC);
            state_reg    <= ST_WLOW;
          end
          else if (guard_reg > 32'h1)
          begin
            guard_reg <= guard_reg - 32'h1;
          end
          else
          begin
            // source starved past the load window; abandon the sector
            flash_dq_oe_n_o <= 1'b1;
            timeout_o       <= 1'b1;
            done_o          <= 1'b1;
            state_reg       <= ST_IDLE;
          end
        end
        ST_POLLLO:
        begin
          // same address throughout, read pulse on output gate
          flash_ce_n_o <= 1'b0;
          flash_oe_n_o <= 1'b0;
          timer_reg    <= 32'(fsq_pkg::RD_ACC_CYC);
          state_reg    <= ST_POLLHI;
          guard_reg    <= guard_reg - 32'h1;
        end
        ST_POLLHI:
        begin
          guard_reg <= guard_reg - 32'h1;
          if (timer_reg > 32'h1)
          begin
            timer_reg <= timer_reg - 32'h1;
          end
          else
          begin
            flash_oe_n_o    <= 1'b1;
            flash_ce_n_o    <= 1'b1;
            last_tog_reg    <= dq_s3_reg[6];
            have_sample_reg <= 1'b1;
            timer_reg       <= 32'(fsq_pkg::OE_HIGH_CYC);
            // done once the toggle line settles and polling bit is true
            if (have_sample_reg && dq_s3_reg[6] == last_tog_reg &&
                dq_s2_reg[6] == dq_s3_reg[6] &&
                dq_s3_reg[7] == last_b7_reg)
            begin
              done_o    <= 1'b1;
              state_reg <= ST_DONE;
            end
            else if (guard_reg <= 32'h1)
            begin
              timeout_o <= 1'b1;
              done_o    <= 1'b1;
              state_reg <= ST_DONE;
            end
            else
            begin
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT:
        begin
          if (timer_reg > 32'h1)
          begin
            timer_reg <= timer_reg - 32'h1;
            if (op_reg == fsq_pkg::FSQ_OP_PROGRAM)
            begin
              guard_reg <= guard_reg - 32'h1;
            end
          end
          else if (op_reg == fsq_pkg::FSQ_OP_PROGRAM)
          begin
            state_reg <= ST_POLLLO;
          end
          else
          begin
            done_o    <= 1'b1;
            state_reg <= ST_DONE;
          end
        end
        ST_RDLO:
        begin
          if (timer_reg > 32'h1)
          begin
            timer_reg <= timer_reg - 32'h1;
          end
          else
          begin
            // sampler latency covered by access time margin
            rdata_o       <= dq_s3_reg;
            rdata_valid_o <= 1'b1;
            done_o        <= 1'b1;
            flash_oe_n_o  <= 1'b1;
            flash_ce_n_o  <= 1'b1;
            timer_reg     <= 32'(fsq_pkg::OE_HIGH_CYC);
            state_reg     <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          // gate stays high a full recovery before the next access
          if (timer_reg > 32'h1)
          begin
            timer_reg <= timer_reg - 32'h1;
          end
          else
          begin
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== rtl/fsq_pkg.sv ====
package fsq_pkg;

  // command data and addresses (fifteen low address lines)
  localparam logic [14:0] CMD_ADDR_A   = 15'h5555;
  localparam logic [14:0] CMD_ADDR_B   = 15'h2aaa;
  localparam logic [7:0]  CMD_DATA_AA  = 8'haa;
  localparam logic [7:0]  CMD_DATA_55  = 8'h55;
  localparam logic [7:0]  CMD_PROTECT  = 8'ha0;
  localparam logic [7:0]  CMD_ID_ENTER = 8'h90;
  localparam logic [7:0]  CMD_ID_EXIT  = 8'hf0;
  localparam logic [7:0]  CMD_LOCKOUT  = 8'h80;
  localparam logic [7:0]  CMD_LOCK_LO  = 8'h40;
  localparam logic [7:0]  CMD_LOCK_HI  = 8'h60;

  // sector geometry, buffer depth and data width
  localparam int          SECTOR_BYTES = 256;
  localparam int          FIFO_DEPTH   = 32;
  localparam int          DATA_W       = 8;

  // timing figures and their cycle counts at 100 MHz
  localparam int          CLK_MHZ        = 100;
  localparam int          WR_PULSE_NS    = 200;
  localparam int          WR_HIGH_NS     = 200;
  localparam int          OE_HIGH_NS     = 150;
  localparam int          RD_ACC_NS      = 200;
  localparam int          BYTE_LOAD_US   = 150;
  localparam int          PROG_CYCLE_MS  = 20;
  localparam int          ID_WAIT_MS     = 20;
  localparam logic [15:0] WR_PULSE_CYC   = 16'((WR_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] WR_HIGH_CYC    = 16'((WR_HIGH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] OE_HIGH_CYC    = 16'((OE_HIGH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RD_ACC_CYC     = 16'((RD_ACC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] BYTE_LOAD_CYC  = 16'(BYTE_LOAD_US * CLK_MHZ);
  localparam int          PROG_CYCLE_CYC = PROG_CYCLE_MS * 1000 * CLK_MHZ;
  localparam int          ID_WAIT_CYC    = ID_WAIT_MS * 1000 * CLK_MHZ;

  // host commands
  typedef enum logic [2:0]
  {
    FSQ_OP_PROGRAM  = 3'h0,
    FSQ_OP_ID_ENTER = 3'h1,
    FSQ_OP_ID_EXIT  = 3'h2,
    FSQ_OP_LOCK_LO  = 3'h3,
    FSQ_OP_LOCK_HI  = 3'h4,
    FSQ_OP_READ     = 3'h5
  } fsq_op_t;

endpackage

// ==== rtl/fsq_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none

module fsq_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // valid straight from the occupancy count
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage has no reset, only the pointers, count and ready do
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointer and count bookkeeping
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
      // registered ready: full after this edge, unless a word leaves
      in_ready_o <= !((count_reg == (AW+1)'(DEPTH - 1) && push && !pop) ||
                      (count_reg == (AW+1)'(DEPTH) && !pop));
    end
  end

endmodule

`default_nettype wire

// ==== testbench/fsq_host_properties.sv ====
`timescale 1ns/1ns
`default_nettype none

module fsq_host_chk
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [2:0]  cmd_op_i,
  input wire logic        cmd_valid_i,
  input wire logic        cmd_ready_o,
  input wire logic        done_o,
  input wire logic [17:0] flash_addr_o,
  input wire logic        flash_oe_n_o,
  input wire logic        flash_we_n_o,
  input wire logic        flash_dq_oe_n_o
);
  logic        we_q;
  logic        prog_q;
  logic [31:0] lo_cnt;
  logic [31:0] wr_cnt;
  logic [31:0] gap_cnt;
  wire         we_fall = we_q & ~flash_we_n_o;
  wire         take    = cmd_valid_i & cmd_ready_o;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // strobe history and length of the low phase
  always_ff @(posedge clk_i)
    we_q <= flash_we_n_o | ~rst_n_i;
  always_ff @(posedge clk_i)
    lo_cnt <= (flash_we_n_o | ~rst_n_i) ? 32'h0 : lo_cnt + 32'h1;
  // writes of one command and the spacing between them
  always_ff @(posedge clk_i)
    wr_cnt <= (take | ~rst_n_i) ? 32'h0 : wr_cnt + {31'h0, we_fall};
  always_ff @(posedge clk_i)
    gap_cnt <= (we_fall | ~rst_n_i) ? 32'h0 : gap_cnt + 32'h1;
  // only program commands are held to the full-sector count
  always_ff @(posedge clk_i)
    if (!rst_n_i || done_o)
      prog_q <= 1'b0;
    else if (take)
      prog_q <= (cmd_op_i == fsq_pkg::FSQ_OP_PROGRAM);

  a_write_drives: assert property (!flash_we_n_o |->
    !flash_dq_oe_n_o && flash_oe_n_o) else $error("write without drive");
  a_read_released: assert property (!flash_oe_n_o |->
    flash_dq_oe_n_o && flash_we_n_o) else $error("read while driving");
  a_pulse_width: assert property ($rose(flash_we_n_o) |->
    lo_cnt >= 32'(fsq_pkg::WR_PULSE_CYC)) else $error("write pulse short");
  a_write_recovery: assert property ($rose(flash_we_n_o) |->
    flash_we_n_o [*8]) else $error("write high phase short");
  a_gate_pulse: assert property ($rose(flash_oe_n_o) |->
    flash_oe_n_o [*8]) else $error("gate high pulse short");
  a_poll_addr_hold: assert property (!flash_oe_n_o &&
    $past(flash_oe_n_o) == 1'b0 |-> $stable(flash_addr_o))
    else $error("address moved during read");
  a_full_sector: assert property (done_o && prog_q &&
    wr_cnt > 32'd3 |-> wr_cnt == 32'd259) else $error("partial sector");
  a_load_spacing: assert property (we_fall && prog_q &&
    wr_cnt >= 32'd3 |-> gap_cnt <= 32'(fsq_pkg::BYTE_LOAD_CYC))
    else $error("byte loads too far apart");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_take_busy: assert property (take |=> !cmd_ready_o)
    else $error("ready stayed high after take");
  a_read_answer: assert property (take && cmd_op_i ==
    fsq_pkg::FSQ_OP_READ |-> ##[1:60] done_o) else $error("read slow");
endmodule

bind fsq_host fsq_host_chk u_chk
(
  .clk_i           (clk_i),
  .rst_n_i         (rst_n_i),
  .cmd_op_i        (cmd_op_i),
  .cmd_valid_i     (cmd_valid_i),
  .cmd_ready_o     (cmd_ready_o),
  .done_o          (done_o),
  .flash_addr_o    (flash_addr_o),
  .flash_oe_n_o    (flash_oe_n_o),
  .flash_we_n_o    (flash_we_n_o),
  .flash_dq_oe_n_o (flash_dq_oe_n_o)
);

`default_nettype wire

// ==== testbench/fsq_flash_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module fsq_flash_model
#(
  parameter int         BUSY_CYC = 400,
  parameter int         BLC_CYC  = 15000,
  parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary value
  parameter logic [7:0] PART_ID  = 8'hc3  // arbitrary value
)
(
  input  wire logic        clk_i,
  input  wire logic [17:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [7:0]  dq_i,
  output var  logic [7:0]  dq_o,
  output var  int          viol_o
);
  localparam logic [22:0] W_AA = {fsq_pkg::CMD_ADDR_A, fsq_pkg::CMD_DATA_AA};
  localparam logic [22:0] W_55 = {fsq_pkg::CMD_ADDR_B, fsq_pkg::CMD_DATA_55};
  logic [7:0]  mem [logic [17:0]];
  logic [22:0] h [0:5];
  logic        wr, rd, pre, load, id_mode, lk_lo, lk_hi, polled;
  logic        wr_q = 1'b0;
  logic        rd_q = 1'b0;
  logic        tog = 1'b1;
  logic [7:0]  last, rd_val;
  logic [9:0]  sect;
  logic [17:0] poll_a;
  int          loads, busy, gap;

  function automatic logic [22:0] wa(input logic [7:0] d);
    return {fsq_pkg::CMD_ADDR_A, d};
  endfunction

  // power-up: normal array mode, write protected, nothing locked
  initial
  begin
    {load, id_mode, lk_lo, lk_hi, polled} = '0;
    {busy, gap, loads, viol_o} = '0;
    {last, rd_val, dq_o} = '0;
    for (int i = 0; i < 6; i++) h[i] = '0;
  end

  // edge-driven device seen through the host clock
  always @(posedge clk_i)
  begin
    wr = !we_n_i && !ce_n_i;
    rd = !oe_n_i && !ce_n_i && we_n_i;
    if (busy > 0)
      busy--;
    if (load)
      gap++;
    if (load && gap > BLC_CYC)
    begin
      load = 1'b0;
      viol_o += (loads != 0);
    end
    if (wr && !wr_q && busy > 0)
      viol_o++;
    else if (wr && !wr_q && load)
    begin
      viol_o += (loads != 0 && addr_i[17:8] !== sect);
      sect = addr_i[17:8];
      last = dq_i;
      if (!(lk_lo && sect < 10'd32) && !(lk_hi && sect >= 10'd992))
        mem[addr_i] = dq_i;
      loads++;
      gap = 0;
      if (loads == 256)
      begin
        load = 1'b0;
        busy = BUSY_CYC;
        polled = 1'b0;
      end
    end
    else if (wr && !wr_q)
    begin
      for (int i = 5; i > 0; i--) h[i] = h[i-1];
      h[0] = {addr_i[14:0], dq_i};
      pre = h[2] == W_AA && h[1] == W_55;
      if (pre && h[0] == wa(fsq_pkg::CMD_PROTECT))
        {load, loads, gap} = {1'b1, 32'h0, 32'h0};
      if (pre && h[0] == wa(fsq_pkg::CMD_ID_ENTER))
        id_mode = 1'b1;
      if (pre && h[0] == wa(fsq_pkg::CMD_ID_EXIT))
        id_mode = 1'b0;
      if (pre && h[5] == W_AA && h[4] == W_55 &&
          h[3] == wa(fsq_pkg::CMD_LOCKOUT))
      begin
        lk_lo |= h[0] == wa(fsq_pkg::CMD_LOCK_LO);
        lk_hi |= h[0] == wa(fsq_pkg::CMD_LOCK_HI);
      end
    end
    if (rd && !rd_q && busy > 0)
    begin
      viol_o += (polled && addr_i !== poll_a);
      polled = 1'b1;
      poll_a = addr_i;
      tog = ~tog;
      rd_val = {~last[7], tog, last[5:0]};
    end
    else if (rd && !rd_q && id_mode && addr_i[17:1] == 17'h0)
      rd_val = addr_i[0] ? PART_ID : MAKER_ID;
    else if (rd && !rd_q)
      rd_val = mem.exists(addr_i) ? mem[addr_i] : 8'hff;
    // a released bus keeps changing, so a stale sample cannot pass
    dq_o <= rd ? rd_val : ~dq_o;
    wr_q = wr;
    rd_q = rd;
  end
endmodule

`default_nettype wire

// ==== testbench/fsq_host_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module fsq_host_tb_top;
  typedef struct packed
  {
    logic [2:0]  op;
    logic [17:0] addr;
    logic [7:0]  exp;
    logic        chk;
  } fsq_row_t;
  localparam logic [2:0] RD = fsq_pkg::FSQ_OP_READ;
  localparam logic [2:0] PG = fsq_pkg::FSQ_OP_PROGRAM;
  localparam logic [7:0] MK = 8'h3c; // arbitrary value
  localparam logic [7:0] PT = 8'hc3; // arbitrary value
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [2:0]  cmd_op_i = 3'h0;
  logic [9:0]  cmd_sector_i = 10'h0;
  logic [17:0] cmd_addr_i = 18'h0;
  logic        cmd_valid_i = 1'b0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wdata_valid_i = 1'b0;
  logic        cmd_ready_o, wdata_ready_o, rdata_valid_o, done_o, timeout_o;
  logic        flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_dq_oe_n_o;
  logic [7:0]  rdata_o, flash_dq_o, mdl_dq, bus_dq, rd;
  logic [17:0] flash_addr_o;
  int          viol, n;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  fsq_row_t    rows [0:7];

  // clock and the shared data wire
  always #5 clk_i = ~clk_i;
  assign bus_dq = flash_dq_oe_n_o ? mdl_dq : flash_dq_o;

  fsq_host #(.PROG_TIMEOUT_CYC(2000), .ID_WAIT_CYC(200)) DUT
  (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_op_i(cmd_op_i),
    .cmd_sector_i(cmd_sector_i), .cmd_addr_i(cmd_addr_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .wdata_i(wdata_i), .wdata_valid_i(wdata_valid_i),
    .wdata_ready_o(wdata_ready_o), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .done_o(done_o), .timeout_o(timeout_o),
    .flash_addr_o(flash_addr_o), .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
    .flash_dq_o(flash_dq_o), .flash_dq_oe_n_o(flash_dq_oe_n_o),
    .flash_dq_i(bus_dq)
  );
  fsq_flash_model #(.MAKER_ID(MK), .PART_ID(PT)) u_flash
  (
    .clk_i(clk_i), .addr_i(flash_addr_o), .ce_n_i(flash_ce_n_o),
    .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o), .dq_i(bus_dq),
    .dq_o(mdl_dq), .viol_o(viol)
  );

  function automatic logic [7:0] pat(input int i);
    return 8'(i) ^ 8'h5a;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one command: wait for ready, hand it over, wait for done
  task automatic issue(input logic [2:0] op, input logic [9:0] sec,
                       input logic [17:0] adr);
    int k;
    k = 0;
    rd = 8'hxx;
    while (cmd_ready_o !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
    end
    {cmd_op_i, cmd_sector_i, cmd_addr_i} = {op, sec, adr};
    cmd_valid_i = 1'b1;
    @(posedge clk_i);
    #1 cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && k < 40000)
    begin
      @(posedge clk_i);
      #1 k++;
      if (rdata_valid_o === 1'b1)
        rd = rdata_o;
    end
    check({7'h0, done_o}, 8'h01);
  endtask

  task automatic push();
    logic ok;
    wdata_i = pat(n);
    ok = 1'b0;
    while (!ok)
    begin
      ok = (wdata_ready_o === 1'b1);
      @(posedge clk_i);
      #1;
    end
    n++;
  endtask

  // fill the buffer until it refuses, then stream the rest while programming
  task automatic prog(input logic [9:0] sec);
    n = 0;
    wdata_i = pat(0);
    wdata_valid_i = 1'b1;
    while (wdata_ready_o === 1'b1)
    begin
      @(posedge clk_i);
      #1 n++;
      wdata_i = pat(n);
    end
    check(8'(n), 8'(fsq_pkg::FIFO_DEPTH));
    fork
      begin
        while (n < 256) push();
        wdata_valid_i = 1'b0;
      end
      issue(PG, sec, 18'h0);
    join
    $display("program of sector %0d done", sec);
  endtask

  // ceiling on the whole run
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 90000)
    begin
      fail_count++;
      $display("Error at %0t: run exceeded cycle ceiling", $time);
      report_and_stop();
    end
  end

  initial
  begin
    rows = '{'{RD, {10'd3, 8'h00}, pat(0), 1'b1},
             '{RD, {10'd3, 8'hff}, pat(255), 1'b1},
             '{fsq_pkg::FSQ_OP_ID_ENTER, 18'h0, 8'h00, 1'b0},
             '{RD, 18'h0, MK, 1'b1},
             '{RD, 18'h1, PT, 1'b1},
             '{fsq_pkg::FSQ_OP_ID_EXIT, 18'h0, 8'h00, 1'b0},
             '{RD, {10'd3, 8'h01}, pat(1), 1'b1},
             '{fsq_pkg::FSQ_OP_LOCK_HI, 18'h0, 8'h00, 1'b0}};
    repeat (12) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    prog(10'd3);
    foreach (rows[i])
    begin
      issue(rows[i].op, 10'h0, rows[i].addr);
      if (rows[i].chk)
        check(rd, rows[i].exp);
      $display("row %0d done", i);
    end
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 check({flash_ce_n_o, flash_we_n_o, flash_oe_n_o, flash_dq_oe_n_o,
              cmd_ready_o, done_o, 2'h0}, 8'hf0);
    rst_n_i = 1'b1;
    $display("mid-run reset done");
    issue(PG, 10'd7, 18'h0);
    check({7'h0, timeout_o}, 8'h01);
    repeat (100) @(posedge clk_i);
    #1 $display("starved program done");
    issue(fsq_pkg::FSQ_OP_LOCK_LO, 10'h0, 18'h0);
    prog(10'd0);
    check({7'h0, timeout_o}, 8'h00);
    issue(RD, 10'h0, {10'd0, 8'h05});
    check(rd, 8'hff);
    check(8'(viol > 0), 8'h00);
    $display("lockout test done");
    report_and_stop();
  end
endmodule

`default_nettype wire
